// ---- core/host_counter_swap_regs.v ----
// Notes on behaviour
// - Timer count read-only, low 16 bits, reset ones
// - Timer runs only while enable is set
// - Word order matters only on 16-bit bus
// - 32-bit bus maps straight, high to high
// - 16-bit normal: A1 high selects upper half
// - 16-bit all-ones order: A1 high selects lower
// - Network side always low half first
// - 32-bit tick counter, zero at reset, increments
// - Tick counter wraps at maximum to zero
// - 16-bit read latches whole tick count first
// - Tick counter cleared within 160 ns
// - Tick counter never gated by power state
// - Dropped counter increments per discarded frame
// - Reading dropped counter clears it
// - Event when dropped counter crosses midpoint
`timescale 1ns/1ps
`default_nettype none
`include "host_counter_swap_regs.vh"
module host_counter_swap_regs (
  input  wire        CORE_CLK_IN,      // 20 MHz core clock
  input  wire        RST_IN,           // Async reset, high
  input  wire        BUS16_IN,         // Host bus is 16 bits wide
  input  wire [7:0]  ADDR_IN,          // Byte address, A[1] used in 16-bit mode
  input  wire        RD_IN,            // Read strobe, one cycle
  input  wire        WR_IN,            // Write strobe, one cycle
  input  wire [31:0] WDATA_IN,         // Write data
  input  wire        TICK_EN_IN,       // 25 MHz cycle enable pulse
  input  wire        TIMER_EN_IN,      // Timer run enable
  input  wire        TIMER_DEC_IN,     // Timer step pulse
  input  wire        FRAME_DROP_IN,    // Received frame discarded
  input  wire [31:0] TX_WORD_IN,       // Transmit FIFO word
  input  wire        TX_HALF_SEL_IN,   // 0 first half, 1 second half
  input  wire [15:0] RX_HALF_IN,       // Received half-word
  input  wire        RX_HALF_VLD_IN,   // Received half-word valid
  output reg  [31:0] RDATA_OUT,        // Read data
  output reg         RDATA_VLD_OUT,    // Read data valid pulse
  output reg  [15:0] TX_HALF_OUT,      // Half-word to network
  output reg  [31:0] RX_WORD_OUT,      // Assembled receive word
  output reg         RX_WORD_VLD_OUT,  // Receive word valid pulse
  output wire        SWAP_ACTIVE_OUT,  // Reversed half mapping active
  output wire        DROP_HALF_EVT_OUT // Dropped-count midpoint pulse
);
  reg  [15:0] timer_reg;
  reg  [31:0] swap_reg;
  reg  [31:0] tick_latch_reg;
  reg         tick_latched_reg;
  reg  [15:0] rx_low_reg;
  reg         rx_have_low_reg;
  wire [31:0] tick_count;
  wire [31:0] drop_count;
  wire        drop_clear;
  wire        upper_sel;
  reg  [31:0] word;
  reg  [31:0] rdata_next;

  function sel_upper;
    input       bus16;
    input [31:0] swap;
    input       a1;
    begin
      // The order register is ignored on a 32-bit bus
      sel_upper = (bus16 && (swap == `SWAP_ALL_ONES)) ? !a1 : a1;
    end
  endfunction

  assign SWAP_ACTIVE_OUT = BUS16_IN && (swap_reg == `SWAP_ALL_ONES);
  assign upper_sel       = sel_upper(BUS16_IN, swap_reg, ADDR_IN[1]);
  // A full 16-bit read of the drop counter clears it on the first half read
  assign drop_clear = RD_IN && ({ADDR_IN[7:2], 2'b00} == `OFS_DROPPED_RX_FRAME);

  tick_counter u_tick (
    .clk_in     (CORE_CLK_IN),
    .rst_in     (RST_IN),
    .tick_en_in (TICK_EN_IN),
    .count_out  (tick_count)
  );

  drop_counter u_drop (
    .clk_in    (CORE_CLK_IN),
    .rst_in    (RST_IN),
    .drop_in   (FRAME_DROP_IN),
    .clear_in  (drop_clear),
    .count_out (drop_count),
    .half_out  (DROP_HALF_EVT_OUT)
  );

  // Timer steps down while enabled; disabling reloads the preset
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      timer_reg <= `RST_TIMER_CURRENT_VALUE;
    end else if (!TIMER_EN_IN) begin
      timer_reg <= `RST_TIMER_CURRENT_VALUE;
    end else if (TIMER_DEC_IN) begin
      timer_reg <= timer_reg - 16'h0001;
    end
  end

  // Only the order register accepts writes; counters ignore them
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      swap_reg <= `RST_HALF_WORD_ORDER;
    end else if (WR_IN && ({ADDR_IN[7:2], 2'b00} == `OFS_HALF_WORD_ORDER)) begin
      if (!BUS16_IN) begin
        swap_reg <= WDATA_IN;
      end else if (upper_sel) begin
        swap_reg <= {WDATA_IN[15:0], swap_reg[15:0]};
      end else begin
        swap_reg <= {swap_reg[31:16], WDATA_IN[15:0]};
      end
    end
  end

  // Tick latch: first half read captures all 32 bits, second half uses them
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tick_latch_reg   <= 32'h00000000;
      tick_latched_reg <= 1'b0;
    end else if (BUS16_IN && RD_IN &&
                 ({ADDR_IN[7:2], 2'b00} == `OFS_FREE_RUNNING_TICK)) begin
      if (!tick_latched_reg) begin
        tick_latch_reg   <= tick_count;
        tick_latched_reg <= 1'b1;
      end else begin
        tick_latched_reg <= 1'b0;
      end
    end
  end

  always @* begin
    case ({ADDR_IN[7:2], 2'b00})
      `OFS_TIMER_CURRENT_VALUE: word = {16'h0000, timer_reg};
      `OFS_HALF_WORD_ORDER:     word = swap_reg;
      `OFS_FREE_RUNNING_TICK:   word = (BUS16_IN && tick_latched_reg) ? tick_latch_reg
                                                                      : tick_count;
      `OFS_DROPPED_RX_FRAME:    word = drop_count;
      default:                  word = 32'h00000000;
    endcase
    if (!BUS16_IN) begin
      rdata_next = word;
    end else if (upper_sel) begin
      rdata_next = {16'h0000, word[31:16]};
    end else begin
      rdata_next = {16'h0000, word[15:0]};
    end
  end

  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RDATA_OUT     <= 32'h00000000;
      RDATA_VLD_OUT <= 1'b0;
    end else begin
      RDATA_VLD_OUT <= RD_IN;
      if (RD_IN) begin
        RDATA_OUT <= rdata_next;
      end
    end
  end

  // Network side ignores the host order setting
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      TX_HALF_OUT     <= 16'h0000;
      RX_WORD_OUT     <= 32'h00000000;
      RX_WORD_VLD_OUT <= 1'b0;
      rx_low_reg      <= 16'h0000;
      rx_have_low_reg <= 1'b0;
    end else begin
      TX_HALF_OUT     <= TX_HALF_SEL_IN ? TX_WORD_IN[31:16] : TX_WORD_IN[15:0];
      RX_WORD_VLD_OUT <= 1'b0;
      if (RX_HALF_VLD_IN) begin
        if (!rx_have_low_reg) begin
          rx_low_reg      <= RX_HALF_IN;
          rx_have_low_reg <= 1'b1;
        end else begin
          RX_WORD_OUT     <= {RX_HALF_IN, rx_low_reg};
          RX_WORD_VLD_OUT <= 1'b1;
          rx_have_low_reg <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- inc/host_counter_swap_regs.vh ----
`ifndef HOST_COUNTER_SWAP_REGS_VH
`define HOST_COUNTER_SWAP_REGS_VH
`define OFS_TIMER_CURRENT_VALUE   8'h90
`define OFS_HALF_WORD_ORDER       8'h98
`define OFS_FREE_RUNNING_TICK     8'h9c
`define OFS_DROPPED_RX_FRAME      8'ha0
`define RST_TIMER_CURRENT_VALUE   16'hffff
`define RST_HALF_WORD_ORDER       32'h00000000
`define RST_FREE_RUNNING_TICK     32'h00000000
`define RST_DROPPED_RX_FRAME      32'h00000000
`define SWAP_ALL_ONES             32'hffffffff
`define DROP_MIDPOINT_BELOW       32'h7fffffff
`define DROP_MIDPOINT             32'h80000000
`define CLEAR_TIME_NS             160
`define CORE_PERIOD_NS            50
`define CLEAR_CYCLES              (`CLEAR_TIME_NS / `CORE_PERIOD_NS)
`endif

// ---- core/tick_counter.v ----
`timescale 1ns/1ps
`default_nettype none
`include "host_counter_swap_regs.vh"
module tick_counter (
  input  wire        clk_in,     // Core clock
  input  wire        rst_in,     // Async reset, high
  input  wire        tick_en_in, // One pulse per 25 MHz cycle
  output reg  [31:0] count_out   // Running count
);
  // No power-state gating: counts in every power state
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= `RST_FREE_RUNNING_TICK;
    end else if (tick_en_in) begin
      count_out <= count_out + 32'h00000001;
    end
  end
endmodule
`default_nettype wire

// ---- core/drop_counter.v ----
`timescale 1ns/1ps
`default_nettype none
`include "host_counter_swap_regs.vh"
module drop_counter (
  input  wire        clk_in,    // Core clock
  input  wire        rst_in,    // Async reset, high
  input  wire        drop_in,   // Frame discarded pulse
  input  wire        clear_in,  // Read side effect
  output reg  [31:0] count_out, // Dropped count
  output reg         half_out   // Midpoint event pulse
);
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= `RST_DROPPED_RX_FRAME;
      half_out  <= 1'b0;
    end else begin
      half_out <= drop_in && !clear_in && (count_out == `DROP_MIDPOINT_BELOW);
      // A drop landing with the clearing read is kept as one
      if (clear_in) begin
        count_out <= drop_in ? 32'h00000001 : 32'h00000000;
      end else if (drop_in) begin
        count_out <= count_out + 32'h00000001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/host_counter_swap_regs_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module hcsr_checker (
  input wire logic        CORE_CLK_IN, RST_IN, BUS16_IN, RD_IN, WR_IN, TICK_EN_IN,
  input wire logic        TIMER_EN_IN, FRAME_DROP_IN, TX_HALF_SEL_IN, RX_HALF_VLD_IN,
  input wire logic        RDATA_VLD_OUT, RX_WORD_VLD_OUT, SWAP_ACTIVE_OUT, DROP_HALF_EVT_OUT,
  input wire logic [7:0]  ADDR_IN,
  input wire logic [15:0] RX_HALF_IN, TX_HALF_OUT,
  input wire logic [31:0] WDATA_IN, TX_WORD_IN, RDATA_OUT, RX_WORD_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence drop_rd; RD_IN && !BUS16_IN && ADDR_IN == 8'ha0 && !FRAME_DROP_IN; endsequence
  sequence tick_rd; RD_IN && !BUS16_IN && ADDR_IN == 8'h9c; endsequence
  sequence rx_pair; !RX_HALF_VLD_IN ##1 RX_HALF_VLD_IN [*2]; endsequence
  a_read_answer: assert property (RD_IN |=> RDATA_VLD_OUT)
    else $error("read not answered");
  a_answer_cause: assert property (RDATA_VLD_OUT |-> $past(RD_IN))
    else $error("answer without read");
  a_timer_idle: assert property (!TIMER_EN_IN [*2] ##0 (RD_IN && !BUS16_IN &&
    ADDR_IN == 8'h90) |=> RDATA_OUT == 32'h0000ffff) else $error("idle timer not ffff");
  a_drop_clear: assert property (drop_rd ##1 drop_rd |=> RDATA_OUT == 32'h0)
    else $error("drop count not cleared");
  a_tick_step: assert property (tick_rd ##1 tick_rd |=>
    RDATA_OUT == $past(RDATA_OUT) + {31'h0, $past(TICK_EN_IN, 2)}) else $error("tick step");
  a_swap_clear: assert property (WR_IN && !BUS16_IN && ADDR_IN == 8'h98 &&
    WDATA_IN == 32'h0 |=> !SWAP_ACTIVE_OUT) else $error("swap stays active");
  a_rx_order: assert property (rx_pair |=> RX_WORD_VLD_OUT &&
    RX_WORD_OUT == {$past(RX_HALF_IN), $past(RX_HALF_IN, 2)}) else $error("rx half order");
  a_tx_low_first: assert property (!$past(RST_IN) |-> TX_HALF_OUT ==
    16'($past(TX_HALF_SEL_IN) ? $past(TX_WORD_IN) >> 16 : $past(TX_WORD_IN)))
    else $error("tx half order");
  a_swap_wide_bus: assert property (!BUS16_IN |-> !SWAP_ACTIVE_OUT)
    else $error("swap active on wide bus");
  a_half_evt_drop: assert property (DROP_HALF_EVT_OUT |-> $past(FRAME_DROP_IN))
    else $error("midpoint event without drop");
endmodule
bind host_counter_swap_regs hcsr_checker hcsr_checker_i (.*);
`default_nettype wire

// ---- verification/host_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  input  wire logic        clk_in,    // Core clock
  input  wire logic [31:0] rdata_in,  // Device read data
  output var  logic        bus16_out, // 16-bit bus
  output var  logic [7:0]  addr_out,  // Byte address
  output var  logic        rd_out,    // Read strobe
  output var  logic        wr_out,    // Write strobe
  output var  logic [31:0] wdata_out  // Write data
);
  initial {bus16_out, addr_out, rd_out, wr_out, wdata_out} = '0;
  // Strobes stay up between calls so back-to-back cycles need no gap
  task automatic acc(input logic b, w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    {bus16_out, wr_out, rd_out, addr_out, wdata_out} = {b, w, !w, a, d};
    @(posedge clk_in);
    #1 q = rdata_in;
  endtask
  task automatic idle;
    {rd_out, wr_out} = 2'b00;
  endtask
endmodule
`default_nettype wire

// ---- verification/host_counter_swap_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_counter_swap_regs_test;
  typedef struct {logic b, w; logic [7:0] a; logic [31:0] d;} row_t;
  row_t rows [12] = '{'{0,0,8'h90,32'hffff}, '{0,1,8'h90,32'h1234}, '{0,0,8'h90,32'hffff},
    '{0,1,8'h98,32'h12345678}, '{0,0,8'h98,32'h12345678}, '{1,0,8'h9a,32'h1234},
    '{1,0,8'h90,32'hffff}, '{0,1,8'h98,32'hffffffff}, '{1,0,8'h90,32'h0},
    '{1,0,8'h92,32'hffff}, '{0,1,8'h98,32'h0}, '{0,0,8'hb0,32'h0}};
  logic        clk = 0, rst = 1, ten = 0, tdec = 0, drop = 0, tsel = 0, rxv = 0;
  logic [15:0] rxh = 16'h0;
  logic [31:0] txw = 32'h11112222, q, c;
  int          errors = 0, cmp_count = 0, cyc = 0;
  wire         b16, rd, wr, rxo_v, rvld, swa;
  wire [7:0]   a;
  wire [15:0]  txh;
  wire [31:0]  wd, rdat, rxo;
  host_cpu_model host_cpu_model_i (.clk_in(clk), .rdata_in(rdat), .bus16_out(b16),
    .addr_out(a), .rd_out(rd), .wr_out(wr), .wdata_out(wd));
  host_counter_swap_regs host_counter_swap_regs_i (.CORE_CLK_IN(clk), .RST_IN(rst),
    .BUS16_IN(b16), .ADDR_IN(a), .RD_IN(rd), .WR_IN(wr), .WDATA_IN(wd), .TICK_EN_IN(1'b1),
    .TIMER_EN_IN(ten), .TIMER_DEC_IN(tdec), .FRAME_DROP_IN(drop), .TX_WORD_IN(txw),
    .TX_HALF_SEL_IN(tsel), .RX_HALF_IN(rxh), .RX_HALF_VLD_IN(rxv), .RDATA_OUT(rdat),
    .RDATA_VLD_OUT(rvld), .TX_HALF_OUT(txh), .RX_WORD_OUT(rxo), .RX_WORD_VLD_OUT(rxo_v),
    .SWAP_ACTIVE_OUT(swa), .DROP_HALF_EVT_OUT());
  always #25 clk = ~clk;
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Ceiling well above the roughly 50 cycles the sequence needs
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 1000) begin
      errors++;
      print_verdict;
    end
  end
  initial begin
    step(5);
    rst = 0;
    foreach (rows[i]) begin
      host_cpu_model_i.acc(rows[i].b, rows[i].w, rows[i].a, rows[i].d, q);
      if (!rows[i].w) chk(rows[i].b ? {16'h0, q[15:0]} : q, rows[i].d);
    end
    host_cpu_model_i.idle();
    drop = 1;
    step(3);
    drop = 0;
    host_cpu_model_i.acc(0, 0, 8'ha0, 0, q);
    chk(q, 32'h3);
    chk({31'h0, rvld}, 32'h1);
    host_cpu_model_i.acc(0, 0, 8'ha0, 0, q);
    chk(q, 32'h0);
    host_cpu_model_i.acc(0, 0, 8'h9c, 0, c);
    host_cpu_model_i.acc(0, 0, 8'h9c, 0, q);
    chk(q, c + 1);
    c = c + 2;
    host_cpu_model_i.acc(1, 0, 8'h9e, 0, q);
    chk({16'h0, q[15:0]}, {16'h0, c[31:16]});
    host_cpu_model_i.idle();
    step(4);
    host_cpu_model_i.acc(1, 0, 8'h9c, 0, q);
    chk({16'h0, q[15:0]}, {16'h0, c[15:0]});
    host_cpu_model_i.idle();
    ten = 1;
    step(1);
    tdec = 1;
    step(2);
    tdec = 0;
    host_cpu_model_i.acc(0, 0, 8'h90, 0, q);
    chk(q, 32'h0000fffd);
    host_cpu_model_i.acc(0, 1, 8'h98, 32'hffffffff, q);
    chk({31'h0, swa}, 32'h0);
    host_cpu_model_i.acc(1, 0, 8'hb0, 0, q);
    chk({31'h0, swa}, 32'h1);
    host_cpu_model_i.acc(0, 1, 8'h98, 32'h0, q);
    host_cpu_model_i.idle();
    step(1);
    chk({31'h0, rvld}, 32'h0);
    ten = 0;
    step(2);
    host_cpu_model_i.acc(0, 0, 8'h90, 0, q);
    chk(q, 32'h0000ffff);
    host_cpu_model_i.idle();
    rxh = 16'haaaa;
    rxv = 1;
    step(1);
    rxh = 16'h5555;
    step(1);
    rxv = 0;
    chk(rxo, 32'h5555aaaa);
    chk({31'h0, rxo_v}, 32'h1);
    tsel = 1;
    step(1);
    chk({16'h0, txh}, 32'h1111);
    rst = 1;
    step(1);
    rst = 0;
    host_cpu_model_i.acc(0, 0, 8'h9c, 0, q);
    chk(q, 32'h0);
    host_cpu_model_i.idle();
    print_verdict;
  end
endmodule
`default_nettype wire
